// ### rtl/iuvfr_pkg.sv
// How it works
// - Read/write byte at 0x5a; bits 7:6 pick the fault reaction.
// - Reaction 00: output keeps running, fault ignored.
// - Reaction 01: keep running for 2^delay times the delay time unit.
// - After that delay, if fault persists, follow the retry count field.
// - Reaction 10: switch output off at once, then follow retry count.
// - Reaction 11: output stays off until the fault is cleared.
// - Retry count 000: no restart; output off until fault cleared.
// - Counts 1 to 6: that many restarts, then off until cleared.
// - Off time from the end of one attempt to the next start is 2^delay times the delay time unit.
// - Count 111: retry forever until commanded off or another fault.
// - Delay field n gives multiplier 2^n, 1 up to 128.
// - Delay time unit length comes from a separate register at 0xd2.
// - Fault comes from input voltage compared with the limit at 0x59.
`default_nettype none
package iuvfr_pkg;
    // ==========================================================
    // Register map and fields
    localparam logic [7:0] IUVFR_ACTION_ADDR     = 8'h5a;
    localparam logic [7:0] IUVFR_UNIT_ADDR       = 8'hd2;
    localparam logic [7:0] IUVFR_LIMIT_ADDR      = 8'h59;
    localparam logic [7:0] IUVFR_ACTION_RESET    = 8'h00;
    localparam int         IUVFR_REACT_HI        = 7;
    localparam int         IUVFR_REACT_LO        = 6;
    localparam int         IUVFR_RETRY_HI        = 5;
    localparam int         IUVFR_RETRY_LO        = 3;
    localparam int         IUVFR_DELAY_HI        = 2;
    localparam int         IUVFR_DELAY_LO        = 0;
    localparam logic [2:0] IUVFR_RETRY_NONE      = 3'h0;
    localparam logic [2:0] IUVFR_RETRY_FOREVER   = 3'h7;
    // ==========================================================
    // Reaction codes
    typedef enum logic [1:0] {
        IUVFR_IGNORE  = 2'b00,
        IUVFR_RUN_ON  = 2'b01,
        IUVFR_RETRY   = 2'b10,
        IUVFR_LATCH   = 2'b11
    } iuvfr_react_t;
    // ==========================================================
    // Machine states
    typedef enum logic [2:0] {
        IUVFR_S_RUN    = 3'b000,
        IUVFR_S_GRACE  = 3'b001,
        IUVFR_S_WAIT   = 3'b010,
        IUVFR_S_TRY    = 3'b011,
        IUVFR_S_LOCKED = 3'b100
    } iuvfr_state_t;
endpackage
`default_nettype wire

// ### rtl/iuvfr_core.sv
`default_nettype none
module iuvfr_core #(
    parameter int UNIT_W  = 16,
    parameter int LIMIT_W = 16,
    parameter int TRY_W   = 16
) (
    input  wire logic               i_clock,
    input  wire logic               i_resetn,
    input  wire logic               i_wr,
    input  wire logic [7:0]         i_addr,
    input  wire logic [7:0]         i_wdata,
    input  wire logic [15:0]        i_wword,
    input  wire logic [LIMIT_W-1:0] i_vin,
    input  wire logic               i_clear,
    input  wire logic               i_cmd_on,
    input  wire logic               i_other_fault,
    input  wire logic               i_tick,
    input  wire logic [TRY_W-1:0]   i_try_cycles,
    output logic [7:0]              o_rdata,
    output logic [15:0]             o_unit,
    output logic                    o_out_en,
    output logic                    o_fault,
    output logic                    o_locked,
    output logic [2:0]              o_tries
);
    // ==========================================================
    // State record
    typedef struct packed {
        logic [7:0]               action;
        logic [15:0]              unit;
        logic [LIMIT_W-1:0]       limit;
        iuvfr_pkg::iuvfr_state_t  st;
        logic [UNIT_W-1:0]        ucnt;
        logic [7:0]               mcnt;
        logic [TRY_W-1:0]         tcnt;
        logic [2:0]               tries;
        logic                     fault;
        logic [7:0]               rdata;
        logic                     out_en;
        logic                     locked;
    } iuvfr_state_rec_t;

    iuvfr_state_rec_t s_q;
    iuvfr_state_rec_t s_d;
    logic             uv;
    logic             unit_done;
    logic             delay_done;
    logic [2:0]       dsel;
    logic [2:0]       rset;
    logic [1:0]       react;
    logic [7:0]       mult_m1;

    // ==========================================================
    // Field decode
    assign react   = s_q.action[iuvfr_pkg::IUVFR_REACT_HI:iuvfr_pkg::IUVFR_REACT_LO];
    assign rset    = s_q.action[iuvfr_pkg::IUVFR_RETRY_HI:iuvfr_pkg::IUVFR_RETRY_LO];
    assign dsel    = s_q.action[iuvfr_pkg::IUVFR_DELAY_HI:iuvfr_pkg::IUVFR_DELAY_LO];
    assign mult_m1 = 8'((9'h001 << dsel) - 9'h001);
    assign uv      = (i_vin < s_q.limit);
    // Unit length counted in ticks so the time base stays outside
    assign unit_done  = i_tick && (s_q.ucnt == UNIT_W'(s_q.unit));
    assign delay_done = unit_done && (s_q.mcnt == mult_m1);

    // Restart budget still open for counts 1..6, or forever
    function automatic logic can_retry(input logic [2:0] r, input logic [2:0] n);
        can_retry = (r == iuvfr_pkg::IUVFR_RETRY_FOREVER) || (n < r);
    endfunction

    // ==========================================================
    // Next state
    always_comb begin
        s_d       = s_q;
        s_d.fault = uv;
        if (i_wr) begin
            if (i_addr == iuvfr_pkg::IUVFR_ACTION_ADDR) begin
                s_d.action = i_wdata;
            end else if (i_addr == iuvfr_pkg::IUVFR_UNIT_ADDR) begin
                s_d.unit = i_wword;
            end else if (i_addr == iuvfr_pkg::IUVFR_LIMIT_ADDR) begin
                s_d.limit = i_wword[LIMIT_W-1:0];
            end
        end
        if (i_addr == iuvfr_pkg::IUVFR_ACTION_ADDR) begin
            s_d.rdata = s_q.action;
        end else begin
            s_d.rdata = 8'h00;                                        // Every address but 0x5a reads as zero
        end
        // Delay timer advances on unit ticks; held clear in RUN, restarted on entry to WAIT and TRY
        if (unit_done) begin
            s_d.ucnt = '0;
            s_d.mcnt = 8'(s_q.mcnt + 8'h01);
        end else if (i_tick) begin
            s_d.ucnt = UNIT_W'(s_q.ucnt + 1'b1);
        end
        case (s_q.st)
            iuvfr_pkg::IUVFR_S_RUN: begin
                s_d.ucnt = '0;
                s_d.mcnt = 8'h00;
                if (uv && i_cmd_on) begin
                    case (react)
                        2'b00: s_d.st = iuvfr_pkg::IUVFR_S_RUN;
                        2'b01: s_d.st = iuvfr_pkg::IUVFR_S_GRACE;
                        2'b10: s_d.st = iuvfr_pkg::IUVFR_S_WAIT;
                        default: s_d.st = iuvfr_pkg::IUVFR_S_LOCKED;
                    endcase
                end
            end
            iuvfr_pkg::IUVFR_S_GRACE: begin
                if (!uv) begin
                    s_d.st = iuvfr_pkg::IUVFR_S_RUN;
                end else if (delay_done) begin
                    s_d.ucnt = '0;
                    s_d.mcnt = 8'h00;
                    if (rset == iuvfr_pkg::IUVFR_RETRY_NONE) begin
                        s_d.st = iuvfr_pkg::IUVFR_S_LOCKED;
                    end else begin
                        s_d.st = iuvfr_pkg::IUVFR_S_WAIT;
                    end
                end
            end
            iuvfr_pkg::IUVFR_S_WAIT: begin
                if (rset == iuvfr_pkg::IUVFR_RETRY_NONE || !can_retry(rset, s_q.tries)) begin
                    s_d.st = iuvfr_pkg::IUVFR_S_LOCKED;
                end else if (delay_done) begin
                    s_d.st    = iuvfr_pkg::IUVFR_S_TRY;
                    s_d.tcnt  = '0;
                    s_d.ucnt  = '0;
                    s_d.mcnt  = 8'h00;
                    if (s_q.tries != 3'h7) begin
                        s_d.tries = 3'(s_q.tries + 3'h1);
                    end
                end
            end
            iuvfr_pkg::IUVFR_S_TRY: begin
                // Attempt lasts a fixed window; spacing counts from its end
                if (s_q.tcnt == i_try_cycles) begin
                    if (!uv) begin
                        s_d.st    = iuvfr_pkg::IUVFR_S_RUN;
                        s_d.tries = 3'h0;
                    end else begin
                        // Fresh spacing timer, else the count wraps
                        s_d.st   = iuvfr_pkg::IUVFR_S_WAIT;
                        s_d.ucnt = '0;
                        s_d.mcnt = 8'h00;
                    end
                end else begin
                    s_d.tcnt = TRY_W'(s_q.tcnt + 1'b1);
                end
            end
            default: begin
                s_d.st = iuvfr_pkg::IUVFR_S_LOCKED;
            end
        endcase
        // Stop sources override the reaction logic outside RUN: command off or other fault
        if (!i_cmd_on || i_other_fault) begin
            if (s_q.st != iuvfr_pkg::IUVFR_S_RUN) begin
                s_d.st = iuvfr_pkg::IUVFR_S_LOCKED;
            end
        end
        // Clear of fault, or command off while locked, releases the latch
        if (i_clear || (!i_cmd_on && s_q.st == iuvfr_pkg::IUVFR_S_LOCKED)) begin
            s_d.st    = iuvfr_pkg::IUVFR_S_RUN;
            s_d.tries = 3'h0;
        end
        s_d.out_en = i_cmd_on && !i_other_fault &&
                     (s_d.st == iuvfr_pkg::IUVFR_S_RUN ||
                      s_d.st == iuvfr_pkg::IUVFR_S_GRACE ||
                      s_d.st == iuvfr_pkg::IUVFR_S_TRY);
        s_d.locked = (s_d.st == iuvfr_pkg::IUVFR_S_LOCKED);
    end

    // ==========================================================
    // State register; synchronous reset zeroes every field, action byte included, and returns to RUN
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            s_q        <= '0;
            s_q.action <= iuvfr_pkg::IUVFR_ACTION_RESET;
            s_q.st     <= iuvfr_pkg::IUVFR_S_RUN;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_rdata  = s_q.rdata;
    assign o_unit   = s_q.unit;
    assign o_out_en = s_q.out_en;
    assign o_fault  = s_q.fault;
    assign o_locked = s_q.locked;
    assign o_tries  = s_q.tries;
endmodule
`default_nettype wire

// ### verification/iuvfr_chk.sv
`default_nettype none
// ====
// Fault response checker
module iuvfr_chk (
    input wire logic       i_clock,
    input wire logic       i_resetn,
    input wire logic       i_wr,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_clear,
    input wire logic       i_cmd_on,
    input wire logic       i_other_fault,
    input wire logic [7:0] o_rdata,
    input wire logic       o_out_en,
    input wire logic       o_fault,
    input wire logic       o_locked,
    input wire logic [2:0] o_tries
);
    logic [7:0] act_q;
    // Shadow action byte, since the body is hidden
    always_ff @(posedge i_clock) begin
        if (!i_resetn) act_q <= 8'h00;
        else if (i_wr && i_addr == 8'h5a) act_q <= i_wdata;
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_resetn);
    // Action write; fresh fault while commanded on
    sequence act_wr_s; i_wr && i_addr == 8'h5a; endsequence
    sequence uv_hit_s; $rose(o_fault) && i_cmd_on; endsequence
    // Read data lags the write by one registered read cycle
    rd_echo_a: assert property (act_wr_s ##1 i_addr == 8'h5a |=> o_rdata == $past(i_wdata, 2))
        else $error("action byte not read back");
    rd_zero_a: assert property (i_addr != 8'h5a |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    retry_off_a: assert property (uv_hit_s ##0 act_q[7:6] == 2'b10 |-> ##[0:1] !o_out_en)
        else $error("output not cut at once");
    latch_off_a: assert property (uv_hit_s ##0 act_q[7:6] == 2'b11 |-> ##[0:2] o_locked)
        else $error("latch reaction not locked");
    locked_off_a: assert property (o_locked |-> !o_out_en)
        else $error("output on while locked");
    tries_cap_a: assert property (act_q[5:3] != 3'h7 |-> o_tries <= act_q[5:3])
        else $error("too many restarts");
    clear_tries_a: assert property (i_clear |=> o_tries == 3'h0 && !o_locked)
        else $error("clear left state behind");
    other_off_a: assert property (i_other_fault |=> !o_out_en)
        else $error("other fault left output on");
endmodule
bind iuvfr_core iuvfr_chk u_chk (
    .i_clock, .i_resetn, .i_wr, .i_addr, .i_wdata, .i_clear, .i_cmd_on,
    .i_other_fault, .o_rdata, .o_out_en, .o_fault, .o_locked, .o_tries
);
`default_nettype wire

// ### verification/iuvfr_host.sv
`default_nettype none
// ====
// Host that programs and selects registers
module iuvfr_host (
    input  wire logic   i_clock,
    output logic        o_wr,
    output logic [7:0]  o_addr,
    output logic [7:0]  o_wdata,
    output logic [15:0] o_wword
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus from time zero
    initial begin
        o_wr = 1'h0;
        o_addr = 8'h00;
        o_wdata = 8'h00;
        o_wword = 16'h0000;
    end
    // Write when we is set, else only a read select; o_wword inverted after
    task automatic xfer(input logic we, input logic [7:0] a, input logic [15:0] w);
        @(posedge i_clock);
        #1;
        o_wr = we;
        o_addr = a;
        o_wdata = w[7:0];
        o_wword = w;
        @(posedge i_clock);
        #1;
        o_wr = 1'h0;
        o_wword = ~w;
    endtask
endmodule
`default_nettype wire

// ### verification/tb_input_uv_fault_response_retry.sv
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
    $display("[FAIL] %s expected %h seen %h", n, e, g); end end
// ====
// Bench top
module tb_input_uv_fault_response_retry;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 1'h0, resetn = 1'h0, clear = 1'h0, cmd_on = 1'h0, other = 1'h0;
    logic        wr, out_en, fault, locked, per_ok, was;
    logic [2:0]  tries;
    logic [7:0]  addr, wdata, rdata;
    logic [15:0] vin = 16'h0200, wword, unit, r;
    int          err_count = 0, n_checks = 0, sel_q[$], rise_q[$];
    logic [15:0] exp_q[$];
    int          ws;
    logic [15:0] we;
    string       nm[6] = '{"rdata", "out_en", "locked", "tries", "unit", "period"};
    event        sample;
    always #20 clock = ~clock;
    iuvfr_host host (.i_clock(clock), .o_wr(wr), .o_addr(addr), .o_wdata(wdata), .o_wword(wword));
    // One tick a cycle, so a delay unit of 0 lasts one cycle
    iuvfr_core uut (.i_clock(clock), .i_resetn(resetn), .i_wr(wr), .i_addr(addr),
        .i_wdata(wdata), .i_wword(wword), .i_vin(vin), .i_clear(clear), .i_cmd_on(cmd_on),
        .i_other_fault(other), .i_tick(1'h1), .i_try_cycles(16'h0003), .o_rdata(rdata),
        .o_unit(unit), .o_out_en(out_en), .o_fault(fault), .o_locked(locked), .o_tries(tries));
    function automatic logic [15:0] obs(input int s);
        logic [15:0] v[6];
        v = '{{8'h00, rdata}, {15'h0000, out_en}, {15'h0000, locked}, {13'h0000, tries},
              unit, {15'h0000, per_ok}};
        return v[s];
    endfunction
    task automatic note(input int s, input logic [15:0] e);
        sel_q.push_back(s);
        exp_q.push_back(e);
        -> sample;
    endtask
    // Watcher drains every note; several may land in one time step
    always @(sample) begin
        while (sel_q.size() > 0) begin
            ws = sel_q.pop_front();
            we = exp_q.pop_front();
            `CHK(nm[ws], we, obs(ws))
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Clear with healthy input, then program the action byte
    task automatic act(input logic [7:0] b);
        vin = 16'h0100 + 16'($urandom_range(0, 255));
        clear = 1'h1;
        cyc(1);
        clear = 1'h0;
        host.xfer(1'h1, 8'h5a, {8'h00, b});
    endtask
    task automatic wait_lock();
        for (int k = 0; k < 400 && locked !== 1'h1; k++) cyc(1);
        if (locked !== 1'h1) begin
            err_count++;
            conclude();
        end
    endtask
    // Main sequence
    initial begin
        void'($urandom(30977));
        cyc(12);
        resetn = 1'h1;
        cmd_on = 1'h1;
        host.xfer(1'h0, 8'h5a, 16'h0000);
        note(0, 16'h0000);
        host.xfer(1'h1, 8'h59, 16'h0100);
        r = 16'($urandom());
        host.xfer(1'h1, 8'hd2, r);
        note(4, r);
        host.xfer(1'h1, 8'hd2, 16'h0000);
        r = {10'h000, 6'($urandom())};
        act(r[7:0]);
        cyc(1);
        note(0, r);
        host.xfer(1'h0, 8'h33, 16'h0000);
        note(0, 16'h0000);
        vin = 16'($urandom_range(0, 255));
        cyc(20);
        note(1, 16'h0001);
        act(8'h43);
        vin = 16'($urandom_range(0, 255));
        cyc(6);
        note(1, 16'h0001);
        cyc(6);
        note(1, 16'h0000);
        for (int n = 1; n <= 6; n++) begin
            act({2'b10, 3'(n), 3'h1});
            vin = 16'($urandom_range(0, 255));
            wait_lock();
            note(3, 16'(n));
        end
        act(8'hba);
        vin = 16'($urandom_range(0, 255));
        for (int i = 0; i < 120; i++) begin
            was = out_en;
            cyc(1);
            if (out_en === 1'h1 && was === 1'h0) rise_q.push_back(i);
        end
        per_ok = rise_q.size() > 2 && (rise_q[2] - rise_q[1]) inside {[7:9]};
        note(5, 16'h0001);
        note(2, 16'h0000);
        other = 1'h1;
        cyc(2);
        note(1, 16'h0000);
        other = 1'h0;
        act(8'hc0);
        vin = 16'($urandom_range(0, 255));
        cyc(5);
        vin = 16'h0200;
        cyc(5);
        note(2, 16'h0001);
        cmd_on = 1'h0;
        cyc(2);
        cmd_on = 1'h1;
        cyc(3);
        note(1, 16'h0001);
        conclude();
    end
endmodule
`default_nettype wire
